// File: hdl/standby_clock_gating.sv
// standby clock gating: run requests for oscillators, pll, core buses
// and peripheral clocks, with key-guarded mask and halt registers on apb.
// assumes the standby controller and apb master run on MCLK, and that
// each enable drives a latch-based clock gate at the clock's destination.
//
// Overview of operation
// - slow internal oscillator runs in every standby state
// - main, fast oscillators and pll stop or run per own mask; pll off in deep-halt and cyclic-run regardless
// - core, system bus and high bus clocks off in halt states
// - oscillator masks reset to 0, so oscillators stop in standby
// - oscillator mask at 1 keeps that oscillator running in standby
// - pll stops in halt and cyclic-halt unless its mask is 1
// - high-voltage oscillator in deep-halt follows monitor control
// - peripheral mask 0 gates its clock off throughout standby
// - peripheral clock resumes by itself on wake-up
// - peripheral mask 1 keeps its clock running in standby
// - deep-halt stops switchable-area clocks even with mask set
// - halted module not reset on wake; software leaves it alone
// - halt bits reset to 1: clocks stopped, writes blocked
// - halt bit at 0 supplies clocks and allows configuration
// - module reset returns halt bits to 1
// - peripheral clock: halt 0 to run; standby also needs mask 1
// - module standby register writable only after its key
// - oscillator and pll masks writable only after clock key
// - oscillator mask register holds its mask in bit 0
// - sampler clock from slow osc when fast stopped, else fast/20
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "standby_clk_consts.svh"

module standby_clock_gating
  import standby_clk_pkg::*;
#(
  parameter int N_PERIPH = 8,
  parameter logic [15:0] SWITCHABLE_MAP = 16'hffff
)
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire standby_t STANDBY_STATE,
  input wire logic MON_DEEP_HALT_HV_RUN,
  output logic SLOW_OSC_RUN,
  output logic MAIN_OSC_RUN,
  output logic FAST_OSC_RUN,
  output logic PLL_RUN,
  output logic HV_OSC_RUN,
  output logic CPU_CLK_EN,
  output logic SYS_BUS_CLK_EN,
  output logic HIGH_BUS_CLK_EN,
  output logic LPS_FROM_SLOW,
  output logic [4:0] LPS_DIVIDE,
  output logic [N_PERIPH-1:0] PERIPH_CLK_EN,
  output logic [N_PERIPH-1:0] PERIPH_WR_BLOCK
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (N_PERIPH < 1 || N_PERIPH > `MAX_PERIPH)
  begin : g_bad_width
    $error("N_PERIPH must lie between 1 and 16");
  end

  gate_state_t s;
  gate_state_t next_s;
  logic in_standby;
  logic halting;
  logic deep;
  logic wr_commit;
  logic rd_take;
  logic [15:0] used;

  // word read from a decoded offset, zero elsewhere
  function automatic logic [31:0] read_word(input logic [11:0] a,
                                            input gate_state_t q);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == `OFF_CLK_KEY)
      w[0] = q.clk_key;
    else if (a == `OFF_MAIN_MASK)
      w[`MASK_BIT] = q.main_mask;
    else if (a == `OFF_FAST_MASK)
      w[`MASK_BIT] = q.fast_mask;
    else if (a == `OFF_PLL_MASK)
      w[`MASK_BIT] = q.pll_mask;
    else if (a == `OFF_MSB_KEY)
      w[0] = q.msb_key;
    else if (a == `OFF_MSB_REG)
      w = {q.stop_request_mask, q.module_halt};
    else if (a == `OFF_STATUS)
      w = {q.periph_en, 8'h00, q.lps_slow, q.core_en, q.hv_run,
           q.pll_run, q.fast_run, q.main_run, 1'b1, 1'b0};
    return w;
  endfunction : read_word

  // true for every offset that the decoder knows
  function automatic logic mapped(input logic [11:0] a);
    return a == `OFF_CLK_KEY || a == `OFF_MAIN_MASK ||
           a == `OFF_FAST_MASK || a == `OFF_PLL_MASK ||
           a == `OFF_MSB_KEY || a == `OFF_MSB_REG || a == `OFF_STATUS;
  endfunction : mapped

  // ------------------------------------------------------------
  // standby decode and bus phases
  // ------------------------------------------------------------
  // unpopulated peripheral bits stay zero, halt bits there held at 1, so status reads are clean
  assign used = 16'((32'h1 << N_PERIPH) - 1);
  assign deep = STANDBY_STATE == ST_DEEP_HALT;
  assign halting = STANDBY_STATE == ST_HALT ||
                   STANDBY_STATE == ST_CYCLIC_HALT;
  assign in_standby = halting || deep;
  // pready is a flop: one wait state, write lands on the ready edge
  assign wr_commit = PSEL && PENABLE && s.pready && PWRITE;
  assign rd_take = PSEL && PENABLE && !s.pready;

  // next state of registers and enables
  always_comb
  begin
    next_s = s;
    next_s.pready = rd_take;
    next_s.pslverr = rd_take && !mapped(PADDR);
    next_s.prdata = rd_take ? read_word(PADDR, s) : 32'h0000_0000;
    if (wr_commit)
    begin
      // keys stay open until a different value is written
      if (PADDR == `OFF_CLK_KEY)
        next_s.clk_key = PWDATA == `UNLOCK_KEY;
      else if (PADDR == `OFF_MSB_KEY)
        next_s.msb_key = PWDATA == `UNLOCK_KEY;
      else if (PADDR == `OFF_MAIN_MASK && s.clk_key)
        next_s.main_mask = PWDATA[`MASK_BIT];
      else if (PADDR == `OFF_FAST_MASK && s.clk_key)
        next_s.fast_mask = PWDATA[`MASK_BIT];
      else if (PADDR == `OFF_PLL_MASK && s.clk_key)
        next_s.pll_mask = PWDATA[`MASK_BIT];
      else if (PADDR == `OFF_MSB_REG && s.msb_key)
      begin
        next_s.module_halt = PWDATA[15:0] | ~used;
        next_s.stop_request_mask = PWDATA[31:`SMASK_LSB] & used;
      end
    end
    // oscillators: stop request reaches a source unless masked
    next_s.main_run = !in_standby || s.main_mask;
    next_s.fast_run = !in_standby || s.fast_mask;
    // pll: off in cyclic run and deep halt, powered down there
    next_s.pll_run = STANDBY_STATE == ST_NORMAL ||
                     (halting && s.pll_mask);
    next_s.hv_run = deep ? MON_DEEP_HALT_HV_RUN : 1'b1;
    next_s.core_en = !in_standby;
    // sampler falls back to the slow source when fast is stopped
    next_s.lps_slow = in_standby && !s.fast_mask;
    next_s.lps_div = next_s.lps_slow ? `LPS_SLOW_DIV
                                     : `LPS_FAST_DIV;
    // peripherals follow from live state, so wake-up restores them
    next_s.periph_en = ~s.module_halt & used &
                       (in_standby ? s.stop_request_mask : 16'hffff) &
                       (deep ? ~SWITCHABLE_MAP : 16'hffff);
    next_s.wr_block = s.module_halt & used;
  end

  // single register for all state; only module reset touches it
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s <= '0;
      s.module_halt <= `HALT_RESET;
      s.stop_request_mask <= `SMASK_RESET;
      s.main_mask <= `MASK_RESET;
      s.fast_mask <= `MASK_RESET;
      s.pll_mask <= `MASK_RESET;
      s.lps_div <= `LPS_FAST_DIV;
      s.main_run <= 1'b1;
      s.fast_run <= 1'b1;
      s.pll_run <= 1'b1;
      s.hv_run <= 1'b1;
      s.core_en <= 1'b1;
      s.wr_block <= `HALT_RESET;
    end
    else
      s <= next_s;
  end

  // ------------------------------------------------------------
  // outputs, each straight from one flop except SLOW_OSC_RUN, tied high
  // ------------------------------------------------------------
  assign PREADY = s.pready;
  assign PRDATA = s.prdata;
  assign PSLVERR = s.pslverr;
  assign SLOW_OSC_RUN = 1'b1;
  assign MAIN_OSC_RUN = s.main_run;
  assign FAST_OSC_RUN = s.fast_run;
  assign PLL_RUN = s.pll_run;
  assign HV_OSC_RUN = s.hv_run;
  assign CPU_CLK_EN = s.core_en;
  assign SYS_BUS_CLK_EN = s.core_en;
  assign HIGH_BUS_CLK_EN = s.core_en;
  assign LPS_FROM_SLOW = s.lps_slow;
  assign LPS_DIVIDE = s.lps_div;
  assign PERIPH_CLK_EN = s.periph_en[N_PERIPH-1:0];
  assign PERIPH_WR_BLOCK = s.wr_block[N_PERIPH-1:0];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // core, buses and oscillators: enables lag the state by one edge
  a_core_gate_off: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    in_standby |=> !CPU_CLK_EN && !SYS_BUS_CLK_EN && !HIGH_BUS_CLK_EN)
    else $error("core clocks running in standby");
  a_main_osc_mask: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    in_standby |=> MAIN_OSC_RUN == $past(s.main_mask))
    else $error("main oscillator ignores its mask");
  a_fast_osc_mask: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    in_standby |=> FAST_OSC_RUN == $past(s.fast_mask))
    else $error("fast oscillator ignores its mask");
  a_osc_wake_run: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    !in_standby |=> MAIN_OSC_RUN && FAST_OSC_RUN)
    else $error("oscillator stopped outside standby");
  a_fast_stop_req: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    in_standby && !s.fast_mask |=> !FAST_OSC_RUN && LPS_FROM_SLOW)
    else $error("fast oscillator not stopped in standby");
  a_pll_deep_off: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    deep |=> !PLL_RUN)
    else $error("pll running in deep halt");
  a_pll_mask_keep: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    halting && s.pll_mask |=> PLL_RUN)
    else $error("masked pll stopped in halt");
  a_pll_default_off: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    halting && !s.pll_mask |=> !PLL_RUN)
    else $error("unmasked pll running in halt");
  a_hv_deep_ctrl: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    deep |=> HV_OSC_RUN == $past(MON_DEEP_HALT_HV_RUN))
    else $error("hv oscillator ignores monitor control");
  // peripherals: halt bits first, then stop masks, then power area
  a_halted_no_clk: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    s.module_halt[0] |=> !PERIPH_CLK_EN[0])
    else $error("halted peripheral clocked");
  a_wr_block_halt: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    1'b1 |=> PERIPH_WR_BLOCK == $past(s.module_halt[N_PERIPH-1:0]))
    else $error("write block does not follow halt bits");
  a_run_when_free: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    !in_standby && !s.module_halt[0] |=> PERIPH_CLK_EN[0])
    else $error("released peripheral not clocked");
  a_periph_mask_off: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    in_standby |=>
      (PERIPH_CLK_EN & ~$past(s.stop_request_mask[N_PERIPH-1:0])) == '0)
    else $error("unmasked peripheral clocked in standby");
  a_periph_mask_on: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    halting && !s.module_halt[0] && s.stop_request_mask[0]
    |=> PERIPH_CLK_EN[0])
    else $error("masked peripheral stopped in halt");
  a_deep_switch_off: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    deep |=> (PERIPH_CLK_EN & SWITCHABLE_MAP[N_PERIPH-1:0]) == '0)
    else $error("switchable peripheral clocked in deep halt");
  a_periph_wake: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    !s.module_halt[0] && !deep ##1 !in_standby && !s.module_halt[0]
    |=> PERIPH_CLK_EN[0])
    else $error("peripheral clock not resumed after wake");
  // key guards and sampler source
  a_key_guard: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    !s.msb_key ##1 !s.msb_key |-> $stable(s.module_halt))
    else $error("module standby written without key");
  a_clk_key_guard: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    !s.clk_key ##1 !s.clk_key |-> $stable(s.main_mask) &&
    $stable(s.fast_mask) && $stable(s.pll_mask))
    else $error("stop mask written without clock key");
  a_lps_divide: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    !LPS_FROM_SLOW |-> LPS_DIVIDE == 5'h14)
    else $error("sampler divide wrong on fast source");
  a_lps_fast_src: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    !in_standby || s.fast_mask |=> !LPS_FROM_SLOW)
    else $error("sampler on slow source while fast runs");

endmodule : standby_clock_gating

// File: hdl/standby_clk_consts.svh
// constants of the standby clock gating block: offsets, keys, resets
// assumes inclusion by the package, the gating module and the bench
`ifndef STANDBY_CLK_CONSTS_SVH
`define STANDBY_CLK_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFF_CLK_KEY 12'h000
`define OFF_MAIN_MASK 12'h004
`define OFF_FAST_MASK 12'h008
`define OFF_PLL_MASK 12'h00c
`define OFF_MSB_KEY 12'h010
`define OFF_MSB_REG 12'h014
`define OFF_STATUS 12'h018

// ------------------------------------------------------------
// field positions, keys, reset values, divider
// ------------------------------------------------------------
`define MASK_BIT 0
`define SMASK_LSB 16
`define UNLOCK_KEY 32'ha5a5a501
`define HALT_RESET 16'hffff
`define SMASK_RESET 16'h0000
`define MASK_RESET 1'b0
`define LPS_FAST_DIV 5'h14
`define LPS_SLOW_DIV 5'h01
`define MAX_PERIPH 16

`endif

// File: hdl/standby_clk_pkg.sv
// types of the standby clock gating block
// assumes the constants header sits beside it
`include "standby_clk_consts.svh"

package standby_clk_pkg;

  // ------------------------------------------------------------
  // chip standby state, one-hot, as supplied by the standby controller
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_NORMAL = 5'b00001,
    ST_HALT = 5'b00010,
    ST_DEEP_HALT = 5'b00100,
    ST_CYCLIC_RUN = 5'b01000,
    ST_CYCLIC_HALT = 5'b10000
  } standby_t;

  // ------------------------------------------------------------
  // whole state of the gating module
  // ------------------------------------------------------------
  typedef struct packed {
    logic clk_key;
    logic msb_key;
    logic main_mask;
    logic fast_mask;
    logic pll_mask;
    logic [15:0] module_halt;
    logic [15:0] stop_request_mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic main_run;
    logic fast_run;
    logic pll_run;
    logic hv_run;
    logic core_en;
    logic lps_slow;
    logic [4:0] lps_div;
    logic [15:0] periph_en;
    logic [15:0] wr_block;
  } gate_state_t;

endpackage : standby_clk_pkg

// File: testbench/standby_ctrl_model.sv
// chip standby controller model: drives the standby state and the
// monitor's deep-halt control as the bench requests them
// assumes it shares the gating block's clock and reset
`timescale 1ns/1ns

module standby_ctrl_model
  import standby_clk_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire standby_t req_state,
  input wire logic req_hv,
  output standby_t state,
  output logic hv_run
);
  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // changes only right after an edge, like the real controller
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_NORMAL;
      hv_run <= 1'b0;
    end
    else
    begin
      state <= req_state;
      hv_run <= req_hv;
    end
  end
endmodule : standby_ctrl_model

// File: testbench/tb_standby_clock_gating.sv
// testbench of the standby clock gating block: apb access, key guards,
// gating in every standby state, reset values
// assumes the constants header and package are compiled beforehand
`timescale 1ns/1ns
`include "standby_clk_consts.svh"

module tb_standby_clock_gating import standby_clk_pkg::*;;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic PREADY, PSLVERR, SLOW_OSC_RUN, MAIN_OSC_RUN, FAST_OSC_RUN;
  logic PLL_RUN, HV_OSC_RUN, CPU_CLK_EN, SYS_BUS_CLK_EN, HIGH_BUS_CLK_EN;
  logic LPS_FROM_SLOW, MON_DEEP_HALT_HV_RUN, er;
  logic req_hv = 1'b0;
  logic [4:0] LPS_DIVIDE;
  logic [7:0] PERIPH_CLK_EN, PERIPH_WR_BLOCK;
  logic [31:0] PRDATA, rd;
  standby_t STANDBY_STATE;
  standby_t req_state = ST_NORMAL;
  standby_t sts [6] = '{ST_HALT, ST_NORMAL, ST_DEEP_HALT, ST_CYCLIC_RUN,
    ST_CYCLIC_HALT, ST_NORMAL};
  int n_mismatch = 0;
  int comparisons = 0;

  always #25 MCLK = ~MCLK;

  standby_clock_gating #(.N_PERIPH(8)) standby_clock_gating_inst (
    .MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PRDATA(PRDATA), .PSLVERR(PSLVERR), .STANDBY_STATE(STANDBY_STATE),
    .MON_DEEP_HALT_HV_RUN(MON_DEEP_HALT_HV_RUN),
    .SLOW_OSC_RUN(SLOW_OSC_RUN), .MAIN_OSC_RUN(MAIN_OSC_RUN),
    .FAST_OSC_RUN(FAST_OSC_RUN), .PLL_RUN(PLL_RUN), .HV_OSC_RUN(HV_OSC_RUN),
    .CPU_CLK_EN(CPU_CLK_EN), .SYS_BUS_CLK_EN(SYS_BUS_CLK_EN),
    .HIGH_BUS_CLK_EN(HIGH_BUS_CLK_EN), .LPS_FROM_SLOW(LPS_FROM_SLOW),
    .LPS_DIVIDE(LPS_DIVIDE), .PERIPH_CLK_EN(PERIPH_CLK_EN),
    .PERIPH_WR_BLOCK(PERIPH_WR_BLOCK));

  standby_ctrl_model standby_ctrl_model_inst (.clk(MCLK), .rst_n(RST_N),
    .req_state(req_state), .req_hv(req_hv), .state(STANDBY_STATE),
    .hv_run(MON_DEEP_HALT_HV_RUN));

  // ------------------------------------------------------------
  // compare, verdict, apb master
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // request held until pready is sampled high; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge MCLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    chk({31'h0, PREADY}, 32'h1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  // ------------------------------------------------------------
  // expected gating: halt f0, stop mask 05, all osc masks m
  // ------------------------------------------------------------
  function automatic logic [21:0] exp_clk(standby_t s, logic m, logic mon);
    logic sb, deep, ls;
    logic [7:0] pe;
    sb = s inside {ST_HALT, ST_DEEP_HALT, ST_CYCLIC_HALT};
    deep = (s == ST_DEEP_HALT);
    ls = sb & !m;
    pe = 8'h0f & (sb ? (deep ? 8'h00 : 8'h05) : 8'hff);
    return {1'b1, !sb | m, !sb | m, (s == ST_NORMAL) | (sb & !deep & m),
      deep ? mon : 1'b1, {3{!sb}}, ls, ls ? 5'h01 : 5'h14, pe};
  endfunction : exp_clk

  task automatic step(input standby_t s, input logic m);
    logic [31:0] got;
    logic [31:0] e;
    @(posedge MCLK);
    req_state <= s;
    repeat (2) @(posedge MCLK);
    @(negedge MCLK);
    got = {10'h0, SLOW_OSC_RUN, MAIN_OSC_RUN, FAST_OSC_RUN, PLL_RUN,
      HV_OSC_RUN, CPU_CLK_EN, SYS_BUS_CLK_EN, HIGH_BUS_CLK_EN,
      LPS_FROM_SLOW, LPS_DIVIDE, PERIPH_CLK_EN};
    e = {10'h0, exp_clk(s, m, req_hv)};
    chk(got & 32'h38_0000, e & 32'h38_0000);
    chk(got & 32'h4_0000, e & 32'h4_0000);
    chk(got & 32'h2_0000, e & 32'h2_0000);
    chk(got & 32'h1_c000, e & 32'h1_c000);
    chk(got & 32'h3f00, e & 32'h3f00);
    chk(got & 32'hff, e & 32'hff);
  endtask : step

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge MCLK);
    RST_N <= 1'b1;
    @(negedge MCLK);
    chk({16'h0, PERIPH_CLK_EN, PERIPH_WR_BLOCK}, 32'h00ff);
    apb(1'b0, `OFF_MAIN_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `OFF_PLL_MASK, 32'h1);
    apb(1'b0, `OFF_PLL_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `OFF_MSB_REG, 32'h0005_fff0);
    apb(1'b0, `OFF_MSB_REG, 32'h0);
    chk(rd, 32'h0000_ffff);
    apb(1'b1, `OFF_CLK_KEY, `UNLOCK_KEY);
    apb(1'b1, `OFF_MSB_KEY, `UNLOCK_KEY);
    apb(1'b1, `OFF_MSB_REG, 32'h0005_fff0);
    apb(1'b0, `OFF_MSB_REG, 32'h0);
    chk(rd, 32'h0005_fff0);
    chk({24'h0, PERIPH_WR_BLOCK}, 32'hf0);
    // unmapped place: error flagged, data zero
    apb(1'b0, 12'h01c, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    // both mask settings, every standby state, monitor control following
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, `OFF_MAIN_MASK, {31'h0, m[0]});
      apb(1'b1, `OFF_FAST_MASK, {31'h0, m[0]});
      apb(1'b1, `OFF_PLL_MASK, {31'h0, m[0]});
      apb(1'b0, `OFF_FAST_MASK, 32'h0);
      chk(rd, {31'h0, m[0]});
      req_hv <= m[0];
      foreach (sts[i])
        step(sts[i], m[0]);
    end
    // halt and mask bits survive every standby exit
    apb(1'b0, `OFF_MSB_REG, 32'h0);
    chk(rd, 32'h0005_fff0);
    chk({31'h0, er}, 32'h0);
    // module reset in mid-run brings halt bits back
    @(posedge MCLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    apb(1'b0, `OFF_MSB_REG, 32'h0);
    chk(rd, 32'h0000_ffff);
    chk({24'h0, PERIPH_WR_BLOCK}, 32'hff);
    // status after reset: sources and core running, peripherals off
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_007e);
    stop_test;
  end

  // hang guard, far beyond the 150 or so cycles the tests need
  initial
  begin
    #2000000;
    n_mismatch++;
    stop_test;
  end
endmodule : tb_standby_clock_gating
